// >>> src/seail_pkg.sv
// constants, layouts and carrier types of the eeprom auto-init loader
// assumes a 100 MHz device clock and a 16-bit register/RAM word space
package seail_pkg;

  // clock and eeprom serial clock rates, in kHz
  localparam int CLK_KHZ  = 100_000;
  localparam int SCK_KHZ  = 8_300;
  // half period is a least time: round up
  localparam int SCK_HALF = (CLK_KHZ + 2 * SCK_KHZ - 1) / (2 * SCK_KHZ);
  localparam logic [2:0] SCK_HALF_CNT = 3'(SCK_HALF - 1);

  localparam logic [7:0] EE_READ_CMD = 8'h03;
  localparam logic [4:0] CMD_FALLS   = 5'h18;
  localparam logic [4:0] BYTE_LAST   = 5'h07;
  localparam logic [4:0] SYNC_WAIT   = 5'h02;

  // register word addresses; bus byte address is four times these
  localparam logic [14:0] REG_CONFIG1  = 15'h0000;
  localparam logic [14:0] REG_STATUS   = 15'h0002;
  localparam logic [14:0] REG_PENDING  = 15'h0006;
  localparam logic [14:0] REG_TIMETAG  = 15'h0008;
  localparam logic [14:0] REG_BITWORD  = 15'h0014;
  localparam logic [14:0] REG_MISMATCH = 15'h001F;
  localparam logic [14:0] CKSUM_ADDR   = 15'h0020;
  localparam logic [14:0] DESC_BASE    = 15'h0200;
  localparam logic [14:0] SHORT_END    = 15'h03FF;
  localparam logic [14:0] FULL_END     = 15'h7FFF;
  localparam logic [6:0]  DESC_LAST    = 7'h7F;
  localparam logic [15:0] DESC_CLEAR   = 16'hF000;

  // configuration register 1 fields
  localparam int CFG_RUN  = 13;
  localparam int CFG_SOFT_RESET_BIT = 0;
  localparam logic [15:0] CFG_SELF = 16'h2001;
  // operating_state fields
  localparam int ST_CKF = 7;
  localparam int ST_RMF = 6;
  localparam int ST_APF = 5;
  localparam logic [15:0] ST_PIN_MASK = 16'hFF00;
  // builtin_test_word fields
  localparam int BW_LOADFAIL = 1;
  localparam int BW_STRAPLO  = 2;
  localparam int BW_MEMFAIL  = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_SYNC    = 4'h0,
    ST_LATCH   = 4'h1,
    ST_CMD     = 4'h3,
    ST_BYTE    = 4'h2,
    ST_WRITE   = 4'h6,
    ST_VERIFY  = 4'h7,
    ST_CHECK   = 4'h5,
    ST_FINISH  = 4'h4,
    ST_DONE    = 4'hC,
    ST_SOFT_RESET_BIT_RD = 4'hD,
    ST_SOFT_RESET_BIT_WR = 4'hF
  } seail_state_type;

  typedef struct packed {
    logic       autoload;
    logic       addrHold;
    logic [4:0] taddr;
    logic       tparity;
    logic       shortRange;
    logic       memTestSkip;
    logic [1:0] strapHi;
    logic       strapLo;
  } seail_pins_type;

  typedef struct packed {
    logic sck;
    logic csN;
    logic mosi;
  } seail_spi_type;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } seail_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } seail_axi_resp_type;

  typedef struct packed {
    seail_state_type st;
    logic [2:0]      div;
    logic [4:0]      cnt;
    logic [6:0]      idx;
    logic            sck;
    logic            csN;
    logic            mosi;
    logic [23:0]     shift;
    logic [7:0]      rx;
    logic            hiHave;
    logic [7:0]      hiByte;
    logic [14:0]     addr;
    logic [15:0]     word;
    logic [15:0]     sum;
    logic [15:0]     ckWord;
    logic            mism;
    logic [14:0]     mismAddr;
    logic            imgRun;
    logic            shortRange;
    logic            hold;
    logic [15:0]     cfg;
    logic [15:0]     status;
    logic [15:0]     bitWord;
    logic [15:0]     mismReg;
    logic            ready;
    logic            intr;
    logic            awHave;
    logic            wHave;
    logic [5:0]      awIdx;
    logic [15:0]     wData;
    logic [1:0]      wStrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [15:0]     rdata;
    seail_pins_type  sync1;
    seail_pins_type  sync2;
    logic            miso1;
    logic            miso2;
  } seail_core_type;

endpackage

// >>> src/seail_loader.sv
// post-reset self-initialization engine: strap latch, eeprom image load
// with read-back and checksum, soft-reset descriptor clean-up, axi4-lite
// assumes pins are asynchronous and the eeprom answers serial reads in mode 3
//
// What this block does
// RULE1: latch strap bits 15,14,2; clear other bits
// RULE2: bit 3 follows memory test unless skipped
// RULE3: soft reset clears primary descriptor state bits
// RULE4: autoload loads image, ready held low
// RULE5: range select low loads whole range
// RULE6: range select high loads lower 1K only
// RULE7: read back each write, flag mismatch
// RULE8: checksum skips four registers, sums 0x20 too
// RULE9: merge byte pairs, write, sum, nonzero fails
// RULE10: image holds complement sum at 0x20
// RULE11: copy checksum word to 0x20 at ready
// RULE12: ready rises when loading completes
// RULE13: error raises interrupt and sets status flag
// RULE14: error sets load-fail bit of test word
// RULE15: keep address of first mismatch only
// RULE16: auto run only if image asks, no fault
// RULE17: host run write overrides, parity still blocks
// RULE18: host starts run after ready if needed
// RULE19: latch autoload, hold, address, parity pins
// RULE20: image overwrites pin mirror only unheld
// RULE21: words stored big-endian, high byte first
// RULE22: autoload low skips load, ready at once
// RULE23: eeprom serial clock at most 8.3 MHz, mode 3
// RULE24: one sequential read from byte zero
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps

module seail_loader
  import seail_pkg::*;
#(
  parameter int RAM_AW = 15
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  seail_pins_type    pins,
  input  wire logic         memoryTestFail,
  input  wire logic         spiMiso,
  output seail_spi_type     spi,
  output logic              readyOut,
  output logic              hardwareInterruptOut,
  output logic              runEnable,
  input  seail_axi_req_type axiReq,
  output seail_axi_resp_type axiResp
);

  if (RAM_AW < 10 || RAM_AW > 15) begin : g_check
    $error("RAM_AW must lie between 10 and 15");
  end

  localparam logic [14:0] RAM_MASK = 15'((1 << RAM_AW) - 1);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // odd parity over the five address bits and the parity bit
  function automatic logic parityBad(input logic [15:0] s);
    return ~(^s[15:10]);
  endfunction

  function automatic logic sumSkip(input logic [14:0] a);
    return (a == REG_STATUS) || (a == REG_PENDING) ||
           (a == REG_TIMETAG) || (a == REG_BITWORD);
  endfunction

  function automatic logic isMapped(input logic [5:0] i);
    return (i == REG_CONFIG1[5:0]) || (i == REG_STATUS[5:0]) ||
           (i == REG_BITWORD[5:0]) || (i == REG_MISMATCH[5:0]);
  endfunction

  function automatic logic [15:0] applyStrb(input logic [15:0] old,
                                            input logic [15:0] val,
                                            input logic [1:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = val[7:0];
    end
    if (strb[1]) begin
      res[15:8] = val[15:8];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state, memory and combinational helpers
  seail_core_type r;
  seail_core_type n;

  logic [15:0] ram [1 << RAM_AW];
  logic [15:0] ramQ;
  logic        ramWe;
  logic [14:0] ramWa;
  logic [15:0] ramWd;
  logic [14:0] ramRa;

  logic        tick;
  logic        awReady;
  logic        wReady;
  logic        arReady;
  logic        commit;
  logic [7:0]  newByte;
  logic [14:0] rangeEnd;
  logic [14:0] descAddr;
  logic        bad;
  logic        err;
  logic [15:0] hostVal;
  logic [5:0]  arIdx;

  assign tick     = (r.div == SCK_HALF_CNT);
  assign awReady  = !r.awHave && !r.bvalid;
  assign wReady   = !r.wHave && !r.bvalid;
  assign arReady  = !r.rvalid;
  assign commit   = r.awHave && r.wHave && !r.bvalid;
  assign newByte  = {r.rx[6:0], r.miso2};
  assign rangeEnd = r.shortRange ? SHORT_END : (FULL_END & RAM_MASK); // [RULE5] [RULE6]
  assign descAddr = DESC_BASE + {6'h00, r.idx, 2'b00};
  assign arIdx    = axiReq.araddr[7:2];

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    n       = r;
    ramWe   = 1'b0;
    ramWa   = r.addr;
    ramWd   = r.word;
    ramRa   = r.addr;
    bad     = 1'b0;
    err     = 1'b0;
    hostVal = applyStrb(r.cfg, r.wData, r.wStrb);

    n.sync1 = pins;
    n.sync2 = r.sync1;
    n.miso1 = spiMiso;
    n.miso2 = r.miso1;
    n.div   = tick ? 3'h0 : r.div + 3'h1;

    unique case (r.st)
      ST_SYNC: begin
        n.cnt = r.cnt + 5'h01;
        if (r.cnt == SYNC_WAIT) begin
          n.st = ST_LATCH;
        end
      end

      ST_LATCH: begin
        n.status = {r.sync2.taddr, r.sync2.tparity, r.sync2.addrHold,
                    r.sync2.autoload, 8'h00};                     // [RULE19]
        n.bitWord             = 16'h0000;                         // [RULE1]
        n.bitWord[15:14]      = r.sync2.strapHi;                  // [RULE1]
        n.bitWord[BW_STRAPLO] = r.sync2.strapLo;                  // [RULE1]
        n.bitWord[BW_MEMFAIL] = !r.sync2.memTestSkip && memoryTestFail; // [RULE2]
        n.shortRange = r.sync2.shortRange;
        n.hold       = r.sync2.addrHold;
        n.cnt        = 5'h00;
        if (r.sync2.autoload) begin
          n.st    = ST_CMD;                                       // [RULE4]
          n.csN   = 1'b0;
          n.div   = 3'h0;
          n.shift = {EE_READ_CMD, 16'h0000};                      // [RULE24]
        end else begin
          n.st    = ST_DONE;                                      // [RULE22]
          n.ready = 1'b1;                                         // [RULE22]
        end
      end

      // mode 3: data driven after the falling edge, sampled on the rising
      ST_CMD: begin
        if (tick) begin
          n.sck = !r.sck;                                         // [RULE23]
          if (r.sck) begin
            n.mosi  = r.shift[23];
            n.shift = {r.shift[22:0], 1'b0};
            n.cnt   = r.cnt + 5'h01;
            if (r.cnt == CMD_FALLS) begin
              n.st   = ST_BYTE;
              n.cnt  = 5'h00;
              n.mosi = 1'b0;
            end
          end
        end
      end

      // write, verify and check fit inside one low half, so the clock never pauses; the eeprom keeps its next bit
      ST_BYTE: begin
        if (tick) begin
          n.sck = !r.sck;                                         // [RULE23]
          if (r.sck) begin
            n.rx  = newByte;
            n.cnt = r.cnt + 5'h01;
            if (r.cnt == BYTE_LAST) begin
              n.cnt = 5'h00;
              if (!r.hiHave) begin
                n.hiByte = newByte;                               // [RULE21]
                n.hiHave = 1'b1;
              end else begin
                n.word   = {r.hiByte, newByte};                   // [RULE9] [RULE21]
                n.hiHave = 1'b0;
                n.st     = ST_WRITE;
              end
            end
          end
        end
      end

      ST_WRITE: begin
        if (!sumSkip(r.addr)) begin
          n.sum = r.sum + r.word;                                 // [RULE8] [RULE9]
        end
        if (r.addr == CKSUM_ADDR) begin
          n.ckWord = r.word;                                      // [RULE8]
        end else if (r.addr == REG_CONFIG1) begin
          n.cfg    = r.word & ~CFG_SELF;                          // [RULE16]
          n.imgRun = r.word[CFG_RUN];
        end else if (r.addr == REG_STATUS) begin
          if (!r.hold) begin
            n.status[15:8] = r.word[15:8];                        // [RULE20]
          end
        end else if (r.addr != REG_BITWORD && r.addr != REG_MISMATCH) begin
          ramWe = 1'b1;                                           // [RULE9]
        end
        n.st = ST_VERIFY;
      end

      ST_VERIFY: begin
        n.st = ST_CHECK;
      end

      ST_CHECK: begin
        if (r.addr == REG_CONFIG1) begin
          bad = |((r.cfg ^ r.word) & ~CFG_SELF);                  // [RULE7]
        end else if (r.addr == REG_STATUS) begin
          bad = !r.hold && (|((r.status ^ r.word) & ST_PIN_MASK)); // [RULE7]
        end else if (r.addr == REG_BITWORD || r.addr == REG_MISMATCH ||
                     r.addr == CKSUM_ADDR) begin
          bad = 1'b0;
        end else begin
          bad = (ramQ != r.word);                                 // [RULE7]
        end
        if (bad && !r.mism) begin
          n.mism     = 1'b1;                                      // [RULE15]
          n.mismAddr = r.addr;                                    // [RULE15]
        end
        if (r.addr == rangeEnd) begin
          n.st  = ST_FINISH;
          n.csN = 1'b1;
        end else begin
          n.addr = r.addr + 15'h0001;                             // [RULE24]
          n.st   = ST_BYTE;
        end
      end

      // errors act only here, once the whole range is through
      ST_FINISH: begin
        err   = (r.sum != 16'h0000) || r.mism;                    // [RULE7] [RULE9]
        ramWe = 1'b1;
        ramWa = CKSUM_ADDR;                                       // [RULE11]
        ramWd = r.ckWord;                                         // [RULE11]
        n.sck   = 1'b1;
        n.ready = 1'b1;                                           // [RULE12]
        n.intr  = err;                                            // [RULE13]
        n.status[ST_CKF]      = (r.sum != 16'h0000);              // [RULE13]
        n.status[ST_RMF]      = r.mism;                           // [RULE13]
        n.bitWord[BW_LOADFAIL] = err;                             // [RULE14]
        if (r.mism) begin
          n.mismReg = {1'b0, r.mismAddr};                         // [RULE15]
        end
        n.cfg[CFG_RUN] = r.imgRun && !err && !parityBad(r.status); // [RULE16]
        n.st = ST_DONE;
      end

      ST_DONE: begin
        n.st = ST_DONE;
      end

      // read-modify-write of each control word, one per two cycles
      ST_SOFT_RESET_BIT_RD: begin
        ramRa = descAddr;
        n.st  = ST_SOFT_RESET_BIT_WR;
      end

      ST_SOFT_RESET_BIT_WR: begin
        ramWe = 1'b1;
        ramWa = descAddr;                                         // [RULE3]
        ramWd = ramQ & ~DESC_CLEAR;                               // [RULE3]
        n.idx = r.idx + 7'h01;
        n.st  = ST_SOFT_RESET_BIT_RD;
        if (r.idx == DESC_LAST) begin
          n.ready = 1'b1;
          n.st    = ST_DONE;
        end
      end

      default: begin
        n.st = ST_SYNC;
      end
    endcase

    ////////////////////////////////////////////////////////////////////////
    // register bus
    if (axiReq.awvalid && awReady) begin
      n.awHave = 1'b1;
      n.awIdx  = axiReq.awaddr[7:2];
    end
    if (axiReq.wvalid && wReady) begin
      n.wHave = 1'b1;
      n.wData = axiReq.wdata[15:0];
      n.wStrb = axiReq.wstrb[1:0];
    end
    if (r.bvalid && axiReq.bready) begin
      n.bvalid = 1'b0;
    end
    if (commit) begin
      n.awHave = 1'b0;
      n.wHave  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = isMapped(r.awIdx) ? RESP_OKAY : RESP_SLVERR;
      // host writes are ignored until ready, answered all the same
      if (r.st == ST_DONE) begin
        if (r.awIdx == REG_CONFIG1[5:0]) begin
          n.cfg          = hostVal & ~CFG_SELF;
          n.cfg[CFG_RUN] = hostVal[CFG_RUN] && !parityBad(r.status); // [RULE17] [RULE18]
          if (hostVal[CFG_SOFT_RESET_BIT]) begin
            n.st      = ST_SOFT_RESET_BIT_RD;                               // [RULE3]
            n.idx     = 7'h00;
            n.ready   = 1'b0;
            n.intr    = 1'b0;
            n.bitWord = 16'h0000;
          end
        end else if (r.awIdx == REG_STATUS[5:0]) begin
          n.status[15:8] = 8'(applyStrb(r.status, r.wData, r.wStrb) >> 8); // [RULE17]
        end
      end
    end

    if (r.rvalid && axiReq.rready) begin
      n.rvalid = 1'b0;
    end
    if (axiReq.arvalid && arReady) begin
      n.rvalid = 1'b1;
      n.rresp  = isMapped(arIdx) ? RESP_OKAY : RESP_SLVERR;
      if (arIdx == REG_CONFIG1[5:0]) begin
        n.rdata = r.cfg;
      end else if (arIdx == REG_STATUS[5:0]) begin
        n.rdata = r.status;
      end else if (arIdx == REG_BITWORD[5:0]) begin
        n.rdata = r.bitWord;
      end else if (arIdx == REG_MISMATCH[5:0]) begin
        n.rdata = r.mismReg;
      end else begin
        n.rdata = 16'h0000;
      end
    end

    // parity fault follows the address bits whoever wrote them
    n.status[ST_APF] = parityBad(n.status);                       // [RULE16] [RULE17]
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r     <= '0;
      r.csN <= 1'b1;
      r.sck <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // no reset on the array: its contents come from the image load or the soft-reset clean-up
  always_ff @(posedge clk) begin
    if (ramWe) begin
      ram[ramWa[RAM_AW-1:0]] <= ramWd;
    end
    ramQ <= ram[ramRa[RAM_AW-1:0]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign spi.sck              = r.sck;
  assign spi.csN              = r.csN;
  assign spi.mosi             = r.mosi;
  assign readyOut             = r.ready;                          // [RULE4] [RULE12]
  assign hardwareInterruptOut = r.intr;
  assign runEnable            = r.cfg[CFG_RUN];

  assign axiResp.awready = awReady;
  assign axiResp.wready  = wReady;
  assign axiResp.bvalid  = r.bvalid;
  assign axiResp.bresp   = r.bresp;
  assign axiResp.arready = arReady;
  assign axiResp.rvalid  = r.rvalid;
  assign axiResp.rdata   = {16'h0000, r.rdata};
  assign axiResp.rresp   = r.rresp;
endmodule

// >>> verification/seail_loader_assertions.sv
// port-level checker for the eeprom auto-init loader
// assumes one clock domain, asynchronous active-low reset
`timescale 1ns/1ps
module seail_loader_checker
  import seail_pkg::*;
#(
  parameter int RAM_AW = 15
) (
  input wire logic          clk,
  input wire logic          resetn,
  input seail_spi_type      spi,
  input wire logic          readyOut,
  input wire logic          hardwareInterruptOut,
  input wire logic          runEnable,
  input seail_axi_req_type  axiReq,
  input seail_axi_resp_type axiResp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  a_busy_not_ready: assert property (!spi.csN |-> !readyOut)
    else $error("ready high while image link selected");
  a_ready_after_link: assert property ($rose(spi.csN) |=> readyOut)
    else $error("ready late after image link released");
  a_intr_at_ready: assert property ($rose(hardwareInterruptOut) |-> $rose(readyOut))
    else $error("interrupt not raised together with ready");
  a_run_when_ready: assert property ($rose(runEnable) |-> readyOut)
    else $error("run enabled before ready");
  a_sck_idle_high: assert property (spi.csN && $past(spi.csN) |-> spi.sck)
    else $error("serial clock moves outside a read");
  // seven high cycles keeps the rate at or below the link limit
  a_sck_high_time: assert property ($rose(spi.sck) && !spi.csN |-> spi.sck[*7] ##1 !spi.sck)
    else $error("serial clock high phase length wrong");
  a_write_answer: assert property (axiReq.awvalid && axiResp.awready && axiReq.wvalid &&
    axiResp.wready |-> ##2 axiResp.bvalid)
    else $error("write response not two cycles after request");
  a_read_answer: assert property (axiReq.arvalid && axiResp.arready |=> axiResp.rvalid)
    else $error("read data not one cycle after request");
  a_unmapped_read: assert property (axiReq.arvalid && axiResp.arready &&
    axiReq.araddr[1:0] == 2'h0 && !(axiReq.araddr inside {8'h00, 8'h08, 8'h50, 8'h7C})
    |=> axiResp.rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule

bind seail_loader seail_loader_checker #(.RAM_AW(RAM_AW)) u_chk (
  .clk(clk), .resetn(resetn), .spi(spi), .readyOut(readyOut),
  .hardwareInterruptOut(hardwareInterruptOut), .runEnable(runEnable),
  .axiReq(axiReq), .axiResp(axiResp)
);

// >>> verification/seail_eeprom_model.sv
// behavioural serial eeprom holding a 1K word image, mode 3 reads
// assumes the host shifts command bits on falling sck, one read per select
`timescale 1ns/1ps
module seail_eeprom_model (
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  output logic     miso,
  output logic     cmdErr
);
  logic [15:0] img [0:1023];
  logic [23:0] cmd;
  int          nRise;
  int          bitIdx;
  initial begin
    miso = 1'b0;
    cmdErr = 1'b0;
  end
  always @(negedge csN) begin
    nRise = 0;
    bitIdx = 0;
  end
  // command sampled on rising sck
  always @(posedge sck) begin
    if (!csN && nRise < 24) begin
      cmd = {cmd[22:0], mosi};
      nRise++;
      if (nRise == 24 && cmd !== 24'h030000) cmdErr = 1'b1;
    end
  end
  // high byte first, msb first; sequential address runs on
  always @(negedge sck) begin
    if (!csN && nRise == 24) begin
      miso = img[(bitIdx >> 4) & 1023][15 - (bitIdx & 15)];
      bitIdx++;
    end else begin
      miso = ~miso;
    end
  end
  // a released line must not look like a held bit
  always @(posedge csN) miso = ~miso;
endmodule

// >>> verification/test_serial_eeprom_auto_init_loader.sv
// self-checking bench for the eeprom auto-init loader
// assumes the eeprom model sits on the serial port, bus master is the bench
`timescale 1ns/1ps
module test_serial_eeprom_auto_init_loader;
  import seail_pkg::*;
  logic               clk;
  logic               resetn;
  logic               memoryTestFail;
  logic               spiMiso;
  logic               readyOut;
  logic               intr;
  logic               runEnable;
  logic               cmdErr;
  seail_pins_type     pins;
  seail_spi_type      spi;
  seail_axi_req_type  axiReq;
  seail_axi_resp_type axiResp;
  logic [15:0]        rd;
  logic [1:0]         rsp;
  int                 errTotal;
  int                 checks;

  seail_loader #(.RAM_AW(15)) dut (
    .clk(clk), .resetn(resetn), .pins(pins), .memoryTestFail(memoryTestFail),
    .spiMiso(spiMiso), .spi(spi), .readyOut(readyOut), .hardwareInterruptOut(intr),
    .runEnable(runEnable), .axiReq(axiReq), .axiResp(axiResp)
  );
  seail_eeprom_model ee (
    .sck(spi.sck), .csN(spi.csN), .mosi(spi.mosi), .miso(spiMiso), .cmdErr(cmdErr)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [15:0] d);
    logic aw;
    logic w;
    logic b;
    b = 1'b0;
    axiReq.awaddr <= a;
    axiReq.wdata <= {16'h0000, d};
    axiReq.wstrb <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    while (!b) begin
      @(negedge clk);
      aw = axiReq.awvalid & axiResp.awready;
      w = axiReq.wvalid & axiResp.wready;
      b = axiReq.bready & axiResp.bvalid;
      rsp = axiResp.bresp;
      @(posedge clk);
      if (aw) axiReq.awvalid <= 1'b0;
      if (w) axiReq.wvalid <= 1'b0;
      if (b) axiReq.bready <= 1'b0;
    end
    // response must be withdrawn once taken
    @(posedge clk);
    chk("write answer", 16'h0000, {15'h0000, axiResp.bvalid});
  endtask
  task automatic axr(input logic [7:0] a);
    logic ar;
    logic r;
    r = 1'b0;
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    while (!r) begin
      @(negedge clk);
      ar = axiReq.arvalid & axiResp.arready;
      r = axiReq.rready & axiResp.rvalid;
      rd = axiResp.rdata[15:0];
      rsp = axiResp.rresp;
      @(posedge clk);
      if (ar) axiReq.arvalid <= 1'b0;
      if (r) axiReq.rready <= 1'b0;
    end
    @(posedge clk);
    chk("read answer", 16'h0000, {15'h0000, axiResp.rvalid});
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [15:0] exp);
    axr(a);
    chk(what, exp, rd);
  endtask
  task automatic doReset(input seail_pins_type p);
    pins <= p;
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask
  task automatic waitReady(input logic lvl, input int lim);
    int n;
    n = 0;
    while (readyOut !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("ready", {15'h0000, lvl}, {15'h0000, readyOut});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic scBypass;
    memoryTestFail <= 1'b1;
    doReset('{1'b0, 1'b1, 5'h05, 1'b1, 1'b1, 1'b0, 2'h2, 1'b1});
    waitReady(1'b1, 20);
    rdChk("test word", 8'h50, 16'h800C);
    rdChk("status", 8'h08, 16'h2E00);
    chk("interrupt", 16'h0000, {15'h0000, intr});
    chk("run", 16'h0000, {15'h0000, runEnable});
  endtask
  task automatic scHost;
    axw(8'h08, 16'h2800);
    rdChk("parity flag", 8'h08, 16'h2820);
    axw(8'h00, 16'h2000);
    chk("run blocked", 16'h0000, {15'h0000, runEnable});
    axw(8'h08, 16'h2C00);
    axw(8'h00, 16'h2000);
    chk("run", 16'h0001, {15'h0000, runEnable});
    axr(8'h04);
    chk("unmapped read", {14'h0000, RESP_SLVERR}, {14'h0000, rsp});
    chk("unmapped data", 16'h0000, rd);
    axw(8'hF0, 16'hFFFF);
    chk("unmapped write", {14'h0000, RESP_SLVERR}, {14'h0000, rsp});
  endtask
  task automatic scSoft;
    axw(8'h00, 16'h2001);
    waitReady(1'b0, 10);
    waitReady(1'b1, 600);
    chk("run kept", 16'h0001, {15'h0000, runEnable});
  endtask
  task automatic scLoad;
    logic [15:0] sum;
    sum = 16'h0000;
    for (int i = 0; i < 1024; i++) begin
      ee.img[i] = (i == 0) ? 16'h2000 : {i[7:0], ~i[7:0]};
      if (!(i inside {2, 6, 8, 20, 32})) sum += ee.img[i];
    end
    // one above the true complement, so the tally must end nonzero
    ee.img[32] = 16'h0001 - sum;
    doReset('{1'b1, 1'b1, 5'h05, 1'b1, 1'b1, 1'b1, 2'h2, 1'b1});
    repeat (20) @(posedge clk);
    chk("ready while loading", 16'h0000, {15'h0000, readyOut});
    waitReady(1'b1, 300000);
    chk("interrupt", 16'h0001, {15'h0000, intr});
    chk("checksum copy", ee.img[32], dut.ram[32]);
    rdChk("status", 8'h08, 16'h2F80);
    rdChk("test word", 8'h50, 16'h8006);
    rdChk("first mismatch", 8'h7C, 16'h0000);
    chk("run", 16'h0000, {15'h0000, runEnable});
    chk("read command", 16'h0000, {15'h0000, cmdErr});
    axw(8'h00, 16'h2000);
    chk("run override", 16'h0001, {15'h0000, runEnable});
    // last control word loses its state nibble, its neighbour keeps all
    axw(8'h00, 16'h2001);
    waitReady(1'b1, 600);
    chk("control word", 16'h0C03, dut.ram[15'h03FC]);
    chk("data word", 16'hFD02, dut.ram[15'h03FD]);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d errors %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (400000) @(posedge clk);
    errTotal++;
    conclude;
  end
  initial begin
    resetn = 1'b0;
    pins = '0;
    memoryTestFail = 1'b0;
    axiReq = '0;
    errTotal = 0;
    checks = 0;
    @(posedge clk);
    scBypass;
    scHost;
    scSoft;
    scLoad;
    conclude;
  end
endmodule
